// [include/vcarb_pkg.sv]
package vcarb_pkg;

  // configuration-space byte offsets of the block
  localparam logic [11:0] VCARB_CAP_OFFSET       = 12'h158;
  localparam logic [11:0] VCARB_CTRL_OFFSET      = 12'h15c;
  localparam logic [11:0] VCARB_STAT_OFFSET      = 12'h15e;
  // arbitration table window inside the capability structure
  localparam logic [11:0] VCARB_TABLE_BASE       = 12'h180;
  localparam int          VCARB_TABLE_WORDS      = 4;

  // capability register fields
  localparam int          VCARB_TBL_OFFSET_LSB   = 24;
  localparam logic [7:0]  VCARB_TBL_OFFSET_VAL   = 8'h03;
  localparam logic [7:0]  VCARB_SCHEME_CAP_VAL   = 8'h03;
  localparam logic [2:0]  VCARB_LOW_PRIO_NONE    = 3'h0;
  localparam logic [2:0]  VCARB_LOW_PRIO_DEFAULT = 3'h1;

  // control and status register fields
  localparam int          VCARB_LOAD_BIT         = 0;
  localparam int          VCARB_SELECT_LSB       = 1;
  localparam logic [2:0]  VCARB_SEL_FIXED_RR     = 3'h0;
  localparam logic [2:0]  VCARB_SEL_WRR32        = 3'h1;
  localparam logic [15:0] VCARB_CTRL_RESET       = 16'h0000;
  localparam logic [15:0] VCARB_STAT_RESET       = 16'h0000;

  // cycles one table word takes to copy into the working table
  localparam int          VCARB_COPY_CYCLES      = 1;

  // configuration access from the extended-config decoder
  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } vcarb_cfg_req_t;

  // working arbitration state offered to the arbiter
  typedef struct packed
  {
    logic [2:0]  scheme;
    logic        table_valid;
  } vcarb_arb_cfg_t;

  // load engine states
  typedef enum logic [2:0]
  {
    VCARB_IDLE = 3'b001,
    VCARB_WAIT = 3'b010,
    VCARB_COPY = 3'b100
  } vcarb_state_t;

endpackage

// [hdl/vcarb_table_copy.sv]
`timescale 1ns/100ps
module vcarb_table_copy
#(
  parameter int WORDS = 4
)
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // copy control
  input  wire logic                 start,
  input  wire logic [WORDS*32-1:0]  shadow,
  output logic                      done,
  // working table for the arbiter
  output logic [WORDS*32-1:0]       working
);
  import vcarb_pkg::*;

  localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;

  logic [IW-1:0]         idx_reg;      // word being copied
  logic [IW-1:0]         idx_next;
  logic                  busy_reg;     // copy under way
  logic                  busy_next;
  logic [WORDS*32-1:0]   work_reg;     // working table
  logic [WORDS*32-1:0]   work_next;
  logic                  done_reg;     // one-cycle completion pulse
  logic                  done_next;

  // word-serial copy: keeps a single 32-bit path like a real table ram port
  always_comb
  begin
    idx_next  = idx_reg;
    busy_next = busy_reg;
    work_next = work_reg;
    done_next = 1'b0;
    if (start && !busy_reg)
    begin
      busy_next = 1'b1;
      idx_next  = '0;
    end
    else if (busy_reg)
    begin
      work_next[idx_reg*32 +: 32] = shadow[idx_reg*32 +: 32];
      if (idx_reg == IW'(WORDS - 1))
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      else
      begin
        idx_next = idx_reg + 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      idx_reg  <= '0;
      busy_reg <= 1'b0;
      work_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      idx_reg  <= idx_next;
      busy_reg <= busy_next;
      work_reg <= work_next;
      done_reg <= done_next;
    end
  end

  assign done    = done_reg;
  assign working = work_reg;
endmodule

// [hdl/vcarb_config_regs.sv]
// Overview of operation
// [RULE1] table offset reads 00h or 03h by count
// [RULE2] zero offset: table is scratch pad only
// [RULE3] capability field one bit per scheme
// [RULE4] capability reads 00h or 03h by count
// [RULE5] capability bits 23:8 read zero
// [RULE6] select field bits 3:1, reset fixed round-robin
// [RULE7] software writes only codes 000 or 001
// [RULE8] load bit copies table into working tables
// [RULE9] load bit self-clears, reads zero
// [RULE10] any table write sets pending flag
// [RULE11] pending clears only after completed load
// [RULE12] control bits 15:4 read zero, ignore writes
// [RULE13] status bits 15:1 read zero
// [RULE14] low-priority count default follows strict priority
// [RULE15] new table applied only between decisions
// [RULE16] edit during load keeps pending flag
`timescale 1ns/100ps
module vcarb_config_regs
#(
  parameter int TABLE_WORDS = vcarb_pkg::VCARB_TABLE_WORDS
)
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  // strap from the general control register
  input  wire logic                     strict_priority_en,
  // configuration access
  input  wire vcarb_pkg::vcarb_cfg_req_t cfg_req,
  output logic [31:0]                   cfg_rdata,
  output logic                          cfg_hit,
  // arbiter side
  input  wire logic                     arb_decision_idle,
  output vcarb_pkg::vcarb_arb_cfg_t     arb_cfg,
  output logic [TABLE_WORDS*32-1:0]     arb_working_table,
  output logic [2:0]                    low_prio_ext_channel_count
);
  import vcarb_pkg::*;

  localparam int TW = (TABLE_WORDS > 1) ? $clog2(TABLE_WORDS) : 1;

  // configuration-space state
  logic [2:0]                   arb_scheme_select_reg;   // software choice
  logic [2:0]                   arb_scheme_select_next;
  logic                         arb_table_pending_flag_reg;
  logic                         arb_table_pending_flag_next;
  logic [TABLE_WORDS*32-1:0]    shadow_reg;              // software-visible table
  logic [TABLE_WORDS*32-1:0]    shadow_next;
  logic [2:0]                   low_prio_reg;            // strap-derived count
  logic [2:0]                   low_prio_next;
  logic                         strap_done_reg;          // count captured once
  logic                         strap_done_next;
  // applied state
  vcarb_arb_cfg_t               arb_cfg_reg;
  vcarb_arb_cfg_t               arb_cfg_next;
  vcarb_state_t                 state_reg;
  vcarb_state_t                 state_next;
  logic [TABLE_WORDS*32-1:0]    applied_table_reg;       // table the arbiter uses
  logic [TABLE_WORDS*32-1:0]    applied_table_next;
  logic                         copied_reg;              // copy done, gap awaited
  logic                         copied_next;
  logic                         edit_in_load_reg;        // edit arrived mid-load
  logic                         edit_in_load_next;
  logic [31:0]                  rdata_reg;
  logic [31:0]                  rdata_next;
  logic                         hit_reg;
  logic                         hit_next;
  // copy engine handshake
  logic                         copy_start;
  logic                         copy_done;
  logic [TABLE_WORDS*32-1:0]    copy_table;              // copy engine output
  logic                         load_apply;              // new table goes live
  // decode helpers
  logic                         table_hit;
  logic [TW-1:0]                table_idx;
  logic                         arb_table_load_strobe;
  logic [7:0]                   arb_table_offset;
  logic [7:0]                   arb_scheme_capability;
  logic                         table_write;

  // address decode of the table window
  always_comb
  begin
    table_hit = (cfg_req.addr >= VCARB_TABLE_BASE) &&
                (cfg_req.addr < VCARB_TABLE_BASE + 12'(TABLE_WORDS * 4));
    table_idx = TW'((cfg_req.addr - VCARB_TABLE_BASE) >> 2);
    table_write = cfg_req.wr && table_hit;
    // [RULE8] load strobe decode
    arb_table_load_strobe = cfg_req.wr && (cfg_req.addr == VCARB_CTRL_OFFSET) &&
                            cfg_req.be[0] && cfg_req.wdata[VCARB_LOAD_BIT];
    // [RULE1] offset field value
    arb_table_offset = (low_prio_reg == VCARB_LOW_PRIO_NONE) ? 8'h00 : VCARB_TBL_OFFSET_VAL;
    // [RULE3] [RULE4] capability field value
    arb_scheme_capability = (low_prio_reg == VCARB_LOW_PRIO_NONE) ? 8'h00
                            : VCARB_SCHEME_CAP_VAL;
  end

  // register writes and strap capture
  always_comb
  begin
    arb_scheme_select_next = arb_scheme_select_reg;
    shadow_next            = shadow_reg;
    low_prio_next          = low_prio_reg;
    strap_done_next        = 1'b1;
    // [RULE14] count default chosen once after reset release
    if (!strap_done_reg)
      low_prio_next = strict_priority_en ? VCARB_LOW_PRIO_NONE : VCARB_LOW_PRIO_DEFAULT;
    // [RULE6] [RULE12] only bits 3:1 are stored
    if (cfg_req.wr && (cfg_req.addr == VCARB_CTRL_OFFSET) && cfg_req.be[0])
    begin
      // [RULE7] reserved codes are kept as written; arbiter falls back
      arb_scheme_select_next = cfg_req.wdata[VCARB_SELECT_LSB +: 3];
    end
    if (table_write)
    begin
      for (int b = 0; b < 4; b++)
        if (cfg_req.be[b])
          shadow_next[table_idx*32 + b*8 +: 8] = cfg_req.wdata[b*8 +: 8];
    end
  end

  // pending flag: set wins over the clear of a finishing load
  always_comb
  begin
    arb_table_pending_flag_next = arb_table_pending_flag_reg;
    edit_in_load_next           = edit_in_load_reg;
    // [RULE16] an edit while a load runs may miss the copy
    if (table_write && (state_reg != VCARB_IDLE))
      edit_in_load_next = 1'b1;
    // [RULE11] clear only once the loaded table is live
    if (load_apply)
    begin
      arb_table_pending_flag_next = edit_in_load_reg;
      edit_in_load_next           = 1'b0;
    end
    // [RULE10] [RULE16] any edit sets, even mid-load
    if (table_write)
      arb_table_pending_flag_next = 1'b1;
  end

  // load sequencing; copy only starts with the arbiter between decisions
  always_comb
  begin
    state_next         = state_reg;
    arb_cfg_next       = arb_cfg_reg;
    applied_table_next = applied_table_reg;
    copied_next        = copied_reg;
    copy_start         = 1'b0;
    load_apply         = 1'b0;
    // [RULE2] table has effect only with a nonzero offset
    arb_cfg_next.table_valid = (arb_table_offset != 8'h00) && arb_cfg_reg.table_valid;
    case (state_reg)
      VCARB_IDLE:
      begin
        if (arb_table_load_strobe)
          state_next = VCARB_WAIT;
        // [RULE15] scheme swaps only between decisions
        if (arb_decision_idle)
          arb_cfg_next.scheme = (arb_scheme_select_reg == VCARB_SEL_WRR32) ? VCARB_SEL_WRR32
                                : VCARB_SEL_FIXED_RR;
      end
      VCARB_WAIT:
      begin
        // [RULE15] start copy between decisions
        if (arb_decision_idle)
        begin
          copy_start = 1'b1;
          state_next = VCARB_COPY;
        end
      end
      VCARB_COPY:
      begin
        // completion pulse is short, remember it until the arbiter pauses
        if (copy_done)
          copied_next = 1'b1;
        // [RULE8] [RULE15] whole image goes live at once, between decisions
        if ((copy_done || copied_reg) && arb_decision_idle)
        begin
          load_apply               = 1'b1;
          copied_next              = 1'b0;
          applied_table_next       = copy_table;
          arb_cfg_next.table_valid = (arb_table_offset != 8'h00);
          state_next               = VCARB_IDLE;
        end
      end
      default:
        state_next = VCARB_IDLE;
    endcase
  end

  // read data mux
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    hit_next   = cfg_req.rd || cfg_req.wr;
    if (cfg_req.rd)
    begin
      if (cfg_req.addr == VCARB_CAP_OFFSET)
        // [RULE5] reserved bits zero
        rdata_next = {arb_table_offset, 16'h0000, arb_scheme_capability};
      else if (cfg_req.addr == VCARB_CTRL_OFFSET)
        // [RULE9] [RULE13] load bit and reserved read zero, status above
        rdata_next = {15'h0000, arb_table_pending_flag_reg,
                      12'h000, arb_scheme_select_reg, 1'b0};
      else if (cfg_req.addr == VCARB_STAT_OFFSET)
        rdata_next = {16'h0000, 15'h0000, arb_table_pending_flag_reg};
      else if (table_hit)
        rdata_next = shadow_reg[table_idx*32 +: 32];
      else
        hit_next = 1'b0;
    end
  end

  // all state registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      arb_scheme_select_reg      <= VCARB_SEL_FIXED_RR;
      arb_table_pending_flag_reg <= 1'b0;
      shadow_reg                 <= '0;
      low_prio_reg               <= VCARB_LOW_PRIO_DEFAULT;
      strap_done_reg             <= 1'b0;
      arb_cfg_reg                <= '0;
      state_reg                  <= VCARB_IDLE;
      rdata_reg                  <= 32'h0000_0000;
      hit_reg                    <= 1'b0;
      applied_table_reg          <= '0;
      copied_reg                 <= 1'b0;
      edit_in_load_reg           <= 1'b0;
    end
    else
    begin
      arb_scheme_select_reg      <= arb_scheme_select_next;
      arb_table_pending_flag_reg <= arb_table_pending_flag_next;
      shadow_reg                 <= shadow_next;
      low_prio_reg               <= low_prio_next;
      strap_done_reg             <= strap_done_next;
      arb_cfg_reg                <= arb_cfg_next;
      state_reg                  <= state_next;
      rdata_reg                  <= rdata_next;
      hit_reg                    <= hit_next;
      applied_table_reg          <= applied_table_next;
      copied_reg                 <= copied_next;
      edit_in_load_reg           <= edit_in_load_next;
    end
  end

  // word-serial copy; its half-filled image never reaches the arbiter
  vcarb_table_copy #(.WORDS(TABLE_WORDS)) i_vcarb_table_copy
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .start   (copy_start),
    .shadow  (shadow_reg),
    .done    (copy_done),
    .working (copy_table)
  );

  assign cfg_rdata                  = rdata_reg;
  assign cfg_hit                    = hit_reg;
  assign arb_cfg                    = arb_cfg_reg;
  assign arb_working_table          = applied_table_reg;
  assign low_prio_ext_channel_count = low_prio_reg;
endmodule

// [bench/vcarb_config_regs_chk.sv]
`timescale 1ns/100ps
module vcarb_config_regs_chk
  import vcarb_pkg::*;
#(
  parameter int TABLE_WORDS = vcarb_pkg::VCARB_TABLE_WORDS
)
(
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rstn,
  // strap and access
  input wire logic                      strict_priority_en,
  input wire vcarb_pkg::vcarb_cfg_req_t cfg_req,
  input wire logic [31:0]               cfg_rdata,
  input wire logic                      cfg_hit,
  // arbiter side
  input wire logic                      arb_decision_idle,
  input wire vcarb_pkg::vcarb_arb_cfg_t arb_cfg,
  input wire logic [TABLE_WORDS*32-1:0] arb_working_table,
  input wire logic [2:0]                low_prio_ext_channel_count
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // no read is answered outside the three registers and the table window
  wire logic unmapped = !(cfg_req.addr inside {VCARB_CAP_OFFSET, VCARB_CTRL_OFFSET,
                          VCARB_STAT_OFFSET}) && (cfg_req.addr[11:4] != 8'h18);

  sequence s_rd(a);
    cfg_req.rd && cfg_req.addr == a;
  endsequence
  // a table edit with a byte enabled, while the count is nonzero
  sequence s_tbl_edit;
    cfg_req.wr && cfg_req.addr[11:4] == 8'h18 && cfg_req.be != 4'h0
      && low_prio_ext_channel_count != 3'h0;
  endsequence

  chk_cap_value: assert property (s_rd(VCARB_CAP_OFFSET) |=> cfg_hit &&
    cfg_rdata == ((low_prio_ext_channel_count == 3'h0) ? 32'h0 :
    {VCARB_TBL_OFFSET_VAL, 16'h0000, VCARB_SCHEME_CAP_VAL}))
    else $error("capability read wrong");
  chk_ctrl_rsvd: assert property (s_rd(VCARB_CTRL_OFFSET) |=> cfg_hit &&
    cfg_rdata[15:4] == 12'h0 && !cfg_rdata[0] && cfg_rdata[31:17] == 15'h0)
    else $error("control reserved or load bit nonzero");
  chk_stat_rsvd: assert property (s_rd(VCARB_STAT_OFFSET) |=> cfg_hit &&
    cfg_rdata[31:1] == 31'h0)
    else $error("status reserved bits nonzero");
  chk_unmapped_miss: assert property (cfg_req.rd && unmapped |=> !cfg_hit
    && cfg_rdata == 32'h0)
    else $error("unmapped read answered");
  chk_idle_quiet: assert property (!cfg_req.rd && !cfg_req.wr |=> !cfg_hit
    && cfg_rdata == 32'h0)
    else $error("answer without request");
  chk_edit_flags: assert property (s_tbl_edit ##1 s_rd(VCARB_STAT_OFFSET)
    |=> cfg_rdata[0])
    else $error("pending flag not set by edit");
  chk_apply_between: assert property (($changed(arb_working_table)
    || $changed(arb_cfg)) |-> $past(arb_decision_idle))
    else $error("arbiter state changed during a decision");
  chk_scratch_pad: assert property (low_prio_ext_channel_count == 3'h0
    |-> !arb_cfg.table_valid)
    else $error("table used while offset reads zero");
endmodule

// [bench/tb_vcarb_config_regs.sv]
`timescale 1ns/100ps
module tb_vcarb_config_regs;
  import vcarb_pkg::*;
  logic           clk_sys = 1'b0;
  logic           rstn = 1'b0;
  logic           strict_priority_en = 1'b0;
  logic           arb_decision_idle = 1'b1;
  vcarb_cfg_req_t cfg_req = '0;
  logic [31:0]    cfg_rdata;
  logic           cfg_hit;
  vcarb_arb_cfg_t arb_cfg;
  logic [127:0]   arb_working_table;
  logic [2:0]     low_prio_ext_channel_count;
  logic [127:0]   tbl;                 // expected table image
  int             miscompares = 0;
  int             n_compared = 0;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  vcarb_config_regs i_vcarb_config_regs
  (
    .clk_sys                    (clk_sys),
    .rstn                       (rstn),
    .strict_priority_en         (strict_priority_en),
    .cfg_req                    (cfg_req),
    .cfg_rdata                  (cfg_rdata),
    .cfg_hit                    (cfg_hit),
    .arb_decision_idle          (arb_decision_idle),
    .arb_cfg                    (arb_cfg),
    .arb_working_table          (arb_working_table),
    .low_prio_ext_channel_count (low_prio_ext_channel_count)
  );

  task check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // strap must be steady before release, it is sampled once afterwards;
  // callers return on a falling edge, so reset spans exactly three cycles
  task do_reset(input logic strap);
    rstn = 1'b0;
    strict_priority_en = strap;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask

  // requests stay up until the next op or idle, so back to back is legal
  task cfg_wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b1;
    cfg_req.addr = a;
    cfg_req.be = be;
    cfg_req.wdata = d;
    @(negedge clk_sys);
  endtask

  // answer stands for one cycle only, so it is taken at this negedge
  task cfg_rd(input logic [11:0] a, input logic [31:0] exp, input logic hit);
    cfg_req.wr = 1'b0;
    cfg_req.rd = 1'b1;
    cfg_req.addr = a;
    @(negedge clk_sys);
    check(cfg_rdata, exp);
    check(cfg_hit, hit);
  endtask

  task idle(input int n);
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask

  // watchdog, far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #100000;
    miscompares++;
    test_done;
  end

  initial
  begin
    do_reset(1'b0);
    check(low_prio_ext_channel_count, 3'h1);
    cfg_rd(12'h158, 32'h0300_0003, 1'b1);
    cfg_rd(12'h15c, 32'h0, 1'b1);
    cfg_rd(12'h15e, 32'h0, 1'b1);
    cfg_rd(12'h170, 32'h0, 1'b0);
    // legal select code only, reserved bits written high
    cfg_wr(12'h15c, 4'hf, 32'h0000_fff2);
    cfg_rd(12'h15c, 32'h0000_0002, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      tbl[i*32 +: 32] = 32'ha5a5_0000 + 32'(i);
      cfg_wr(12'h180 + 12'(i * 4), 4'hf, tbl[i*32 +: 32]);
    end
    cfg_rd(12'h15e, 32'h1, 1'b1);
    cfg_rd(12'h15c, 32'h0001_0002, 1'b1);
    // load while the arbiter is mid-decision must wait
    arb_decision_idle = 1'b0;
    cfg_wr(12'h15c, 4'h1, 32'h3);
    cfg_rd(12'h15c, 32'h0001_0002, 1'b1);
    idle(12);
    check(arb_working_table, 128'h0);
    check(arb_cfg.table_valid, 1'b0);
    cfg_rd(12'h15e, 32'h1, 1'b1);
    arb_decision_idle = 1'b1;
    idle(1);
    // same data rewritten during the copy, so the image is unambiguous
    cfg_wr(12'h184, 4'hf, tbl[63:32]);
    idle(12);
    check(arb_working_table, tbl);
    check(arb_cfg, {3'h1, 1'b1});
    cfg_rd(12'h15e, 32'h1, 1'b1);
    // fresh word, then a load whose copy ends inside a decision
    cfg_wr(12'h18c, 4'hf, 32'h5a5a_0003);
    cfg_wr(12'h15c, 4'h1, 32'h1);
    idle(1);
    arb_decision_idle = 1'b0;
    idle(9);
    check(arb_working_table, tbl);
    check(arb_cfg, {3'h1, 1'b1});
    cfg_rd(12'h15e, 32'h1, 1'b1);
    arb_decision_idle = 1'b1;
    tbl[127:96] = 32'h5a5a_0003;
    idle(4);
    check(arb_working_table, tbl);
    cfg_rd(12'h15e, 32'h0, 1'b1);
    check(arb_cfg, {3'h0, 1'b1});
    // strict priority: offset zero, table is scratch pad
    idle(1);
    do_reset(1'b1);
    check(low_prio_ext_channel_count, 3'h0);
    cfg_rd(12'h158, 32'h0, 1'b1);
    cfg_wr(12'h180, 4'hf, 32'h1234_5678);
    cfg_wr(12'h15c, 4'h1, 32'h1);
    idle(12);
    check(arb_cfg.table_valid, 1'b0);
    test_done;
  end
endmodule

bind vcarb_config_regs vcarb_config_regs_chk #(.TABLE_WORDS(TABLE_WORDS)) i_vcarb_config_regs_chk
(
  .clk_sys                    (clk_sys),
  .rstn                       (rstn),
  .strict_priority_en         (strict_priority_en),
  .cfg_req                    (cfg_req),
  .cfg_rdata                  (cfg_rdata),
  .cfg_hit                    (cfg_hit),
  .arb_decision_idle          (arb_decision_idle),
  .arb_cfg                    (arb_cfg),
  .arb_working_table          (arb_working_table),
  .low_prio_ext_channel_count (low_prio_ext_channel_count)
);
